//--- hw/gpio_ports.sv
// Eight bidirectional ports with pull-ups and port A wake-up
//
// Function
// [R01] Ports a..h mapped at fixed data-memory locations, read and written normally.
// [R02] Reads are not latched; the live pin level is sampled at the read.
// [R03] Written data holds in the output latch until rewritten.
// [R04] Direction 1 makes the pin an input, 0 a CMOS output from the latch.
// [R05] A data bit is the pin logic value, 0 low and 1 high.
// [R06] Pull-up bit 1 connects the weak pull-up, only while the pin is input.
// [R07] Each port A wake bit independently enables wake-up for its pin.
// [R08] While halted, a falling edge on an enabled port A pin requests wake-up.
// [R09] Reading an input pin returns the live pin level.
// [R10] Reading an output pin returns the latch, not the pin.
// [R11] Unimplemented bits ignore writes and read as zero.
// [R12] Direction may change at any time and takes effect at once; here pin_oe changes one edge after the direction register is written.
// [R13] After reset every pin is input with pull-up and wake disabled.
// [R14] Pin level is synchronised before the wake edge detector.
`timescale 1ns/10ps
`include "gpio_defs.svh"
module gpio_ports
   import gpio_pkg::*;
#(
   parameter logic [31:0] PORT_WIDTHS = `GPIO_PORT_WIDTHS
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Data-memory access from the core
   input wire logic [`GPIO_ADDR_W-1:0] mem_addr,
   input wire logic mem_wr,
   input wire logic mem_rd,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata,
   // Core power state
   input wire logic halted,
   output logic wake_req,
   // Pins, one byte per port, port a lowest
   input wire logic [63:0] pin_in,
   output logic [63:0] pin_out,
   output logic [63:0] pin_oe,
   output logic [63:0] pin_pullup
);
   logic [63:0] impl_mask;
   byte_type data_q [8];
   byte_type data_d [8];
   byte_type dir_q [8];
   byte_type dir_d [8];
   byte_type pull_q [8];
   byte_type pull_d [8];
   byte_type wake_q, wake_d;
   byte_type rdata_q, rdata_d;
   logic [63:0] out_q, out_d;
   logic [63:0] oe_q, oe_d;
   logic [63:0] pu_q, pu_d;
   logic [2:0] sel_port;
   reg_kind_type sel_kind;
   logic sel_wake;
   wake_if wk ();

   genvar g;
   generate
      for (g = 0; g < `GPIO_NUM_PORTS; g++)
      begin : g_mask
         if (PORT_WIDTHS[4*g +: 4] > 4'd8)
         begin : g_bad
            $error("port width above eight bits");
         end
         assign impl_mask[8*g +: 8] = 8'(16'h00ff >> (4'd8 - PORT_WIDTHS[4*g +: 4]));
      end
   endgenerate

   // Address decode: three registers per port, then the wake register
   always_comb
   begin
      sel_port = 3'(mem_addr / 5'd3);
      sel_kind = reg_none;
      sel_wake = (mem_addr == `GPIO_ADDR_WAKE);
      if (mem_addr < 5'd24) // [R01]
      begin
         unique case (2'(mem_addr % 5'd3))
            `GPIO_KIND_DATA: sel_kind = reg_data;
            `GPIO_KIND_DIR: sel_kind = reg_dir;
            `GPIO_KIND_PULL: sel_kind = reg_pull;
            default: sel_kind = reg_none;
         endcase
      end
   end

   always_comb
   begin
      byte_type m;
      byte_type live;
      m = '0;
      live = '0;
      for (int p = 0; p < 8; p++)
      begin
         m = impl_mask[8*p +: 8];
         data_d[p] = data_q[p];
         dir_d[p] = dir_q[p];
         pull_d[p] = pull_q[p];
         if (mem_wr && sel_port == 3'(p))
         begin
            if (sel_kind == reg_data)
               data_d[p] = mem_wdata & m; // [R03] [R05] [R11]
            if (sel_kind == reg_dir)
               dir_d[p] = (mem_wdata & m) | ~m; // [R12] [R11]
            if (sel_kind == reg_pull)
               pull_d[p] = mem_wdata & m; // [R06] [R11]
         end
      end
      wake_d = wake_q;
      if (mem_wr && sel_wake)
         wake_d = mem_wdata & impl_mask[7:0]; // [R07]
      // Read: inputs show the pin, outputs the latch
      rdata_d = rdata_q;
      if (mem_rd)
      begin
         m = impl_mask[8*sel_port +: 8];
         live = pin_in[8*sel_port +: 8];
         unique case (sel_kind)
            reg_data: rdata_d = ((dir_q[sel_port] & live) |
                                 (~dir_q[sel_port] & data_q[sel_port])) & m; // [R02] [R09] [R10]
            reg_dir: rdata_d = dir_q[sel_port] & m;
            reg_pull: rdata_d = pull_q[sel_port] & m;
            reg_none: rdata_d = sel_wake ? wake_q : 8'h00;
         endcase
      end
   end

   // Pin drive follows the registers one edge later
   always_comb
   begin
      for (int p = 0; p < 8; p++)
      begin
         out_d[8*p +: 8] = data_q[p];
         oe_d[8*p +: 8] = ~dir_q[p] & impl_mask[8*p +: 8]; // [R04]
         pu_d[8*p +: 8] = pull_q[p] & dir_q[p] & impl_mask[8*p +: 8]; // [R06]
      end
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int p = 0; p < 8; p++)
         begin
            data_q[p] <= `GPIO_RST_DATA;
            dir_q[p] <= `GPIO_RST_DIR; // [R13]
            pull_q[p] <= `GPIO_RST_PULL;
         end
         wake_q <= `GPIO_RST_WAKE;
         rdata_q <= 8'h00;
         out_q <= '0;
         oe_q <= '0;
         pu_q <= '0;
      end
      else
      begin
         for (int p = 0; p < 8; p++)
         begin
            data_q[p] <= data_d[p];
            dir_q[p] <= dir_d[p];
            pull_q[p] <= pull_d[p];
         end
         wake_q <= wake_d;
         rdata_q <= rdata_d;
         out_q <= out_d;
         oe_q <= oe_d;
         pu_q <= pu_d;
      end
   end

   assign wk.pin_level = pin_in[7:0];
   assign wk.wake_enable = wake_q;
   assign wk.halted = halted;

   wake_detect u_wake
   (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .wk(wk)
   );

   assign mem_rdata = rdata_q;
   assign wake_req = wk.wake_req;
   assign pin_out = out_q;
   assign pin_oe = oe_q;
   assign pin_pullup = pu_q;
endmodule : gpio_ports

//--- hw/wake_detect.sv
// Port A falling-edge wake-up detector
`timescale 1ns/10ps
`include "gpio_defs.svh"
module wake_detect
   import gpio_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Samples and result
   wake_if.detect wk
);
   byte_type sync1_q, sync1_d;
   byte_type sync2_q, sync2_d;
   byte_type prev_q, prev_d;
   logic req_q, req_d;

   always_comb
   begin
      sync1_d = wk.pin_level;
      sync2_d = sync1_q;
      prev_d = sync2_q;
      // Only the second stage and its one-edge-delayed copy prev_q feed the edge compare
      req_d = wk.halted && |(prev_q & ~sync2_q & wk.wake_enable); // [R08]
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sync1_q <= 8'hff;
         sync2_q <= 8'hff;
         prev_q <= 8'hff;
         req_q <= 1'b0;
      end
      else
      begin
         sync1_q <= sync1_d; // [R14]
         sync2_q <= sync2_d;
         prev_q <= prev_d;
         req_q <= req_d;
      end
   end

   assign wk.wake_req = req_q;
endmodule : wake_detect

//--- include/gpio_defs.svh
// Register indices, widths and reset values of the port block
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH

`define GPIO_ADDR_W 5
`define GPIO_DATA_W 8
`define GPIO_NUM_PORTS 8

// Register index = port * 3 + kind; wake enable sits past the port triples
`define GPIO_KIND_DATA 2'd0
`define GPIO_KIND_DIR 2'd1
`define GPIO_KIND_PULL 2'd2
`define GPIO_ADDR_WAKE 5'h18

// Port widths per port letter a..h, packed four bits each, port a lowest
`define GPIO_PORT_WIDTHS 32'h8888_8888

`define GPIO_RST_DATA 8'h00
`define GPIO_RST_DIR 8'hff
`define GPIO_RST_PULL 8'h00
`define GPIO_RST_WAKE 8'h00

`endif

//--- include/gpio_pkg.sv
// Types shared by the port block
package gpio_pkg;
   typedef logic [7:0] byte_type;
   typedef enum logic [1:0]
   {
      reg_data = 2'b00,
      reg_dir = 2'b01,
      reg_pull = 2'b10,
      reg_none = 2'b11
   } reg_kind_type;
endpackage : gpio_pkg

//--- include/wake_if.sv
// Pin samples and wake controls passed to the wake detector
`timescale 1ns/10ps
interface wake_if;
   logic [7:0] pin_level;
   logic [7:0] wake_enable;
   logic halted;
   logic wake_req;
   modport core (output pin_level, output wake_enable, output halted, input wake_req);
   modport detect (input pin_level, input wake_enable, input halted, output wake_req);
endinterface : wake_if

//--- tb/gpio_ports_assertions.sv
// Timing and masking checks on the port block
`timescale 1ns/10ps
module gpio_ports_assertions
#(
   parameter logic [31:0] PORT_WIDTHS = 32'h8888_8888
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Core side
   input wire logic [4:0] mem_addr,
   input wire logic mem_wr,
   input wire logic mem_rd,
   input wire logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   input wire logic halted,
   input wire logic wake_req,
   // Pins
   input wire logic [63:0] pin_in,
   input wire logic [63:0] pin_out,
   input wire logic [63:0] pin_oe,
   input wire logic [63:0] pin_pullup
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   property p_pull;
      (pin_pullup & pin_oe) == '0;
   endproperty
   a_pull: assert property (p_pull) else $error("pull-up on driven pin");
   property p_wk_halt;
      wake_req |-> $past(halted);
   endproperty
   a_wk_halt: assert property (p_wk_halt) else $error("wake while running");
   // Each pulse must trace back to one fresh port a fall four edges earlier
   property p_wk_once;
      wake_req |-> |($past(pin_in, 4) & ~$past(pin_in, 3) & 64'h0000_0000_0000_00ff);
   endproperty
   a_wk_once: assert property (p_wk_once) else $error("wake without a pin fall");
   property p_unmap;
      mem_rd && mem_addr > 5'h18 |=> mem_rdata == 8'h00;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   property p_hold;
      !mem_rd |=> $stable(mem_rdata);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_dir;
      mem_wr && mem_addr == 5'h01 |=> ##1 pin_oe[7:0] == ~$past(mem_wdata, 2);
   endproperty
   a_dir: assert property (p_dir) else $error("direction");
   property p_out;
      mem_wr && mem_addr == 5'h00 |=> ##1 pin_out[7:0] == $past(mem_wdata, 2);
   endproperty
   a_out: assert property (p_out) else $error("latch");
   property p_unimpl;
      (pin_oe[15:8] & ~8'((9'h1 << PORT_WIDTHS[7:4]) - 9'h1)) == 8'h00;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("absent pin driven");
endmodule : gpio_ports_assertions

//--- tb/gpio_ports_with_wakeup_test.sv
// Self-checking bench for the port block
`timescale 1ns/10ps
module gpio_ports_with_wakeup_test;
   // Port b cut to four bits to reach absent positions
   localparam logic [31:0] WIDTHS = 32'h8888_8848;
   logic ref_clk = 0, rstn = 0, mem_wr = 0, mem_rd = 0, halted = 0, wake_req;
   logic [4:0] mem_addr = '0;
   logic [7:0] mem_wdata = '0, mem_rdata, wk = '0, lat[8], dir[8], pul[8];
   logic [63:0] pin_in, pin_out, pin_oe, pin_pullup, drv = '0, en = '1;
   int errors = 0, checks = 0, wakes = 0, base;
   gpio_ports #(.PORT_WIDTHS(WIDTHS)) u_gpio_ports (.ref_clk, .rstn, .mem_addr, .mem_wr,
      .mem_rd, .mem_wdata, .mem_rdata, .halted, .wake_req, .pin_in, .pin_out, .pin_oe,
      .pin_pullup);
   pin_model u_pin_model (.ref_clk, .pin_out, .pin_oe, .pin_pullup, .ext_drive(drv),
      .ext_en(en), .pin_in);
   initial forever #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (wake_req === 1'b1) wakes <= wakes + 1;
   function automatic logic [7:0] m(int p);
      return 8'((9'h1 << WIDTHS[p*4 +: 4]) - 9'h1);
   endfunction : m
   function automatic logic [7:0] exp_rd(int a);
      int p = a / 3;
      if (a == 24) return wk;
      if (a > 24) return 8'h00;
      if (a % 3 == 1) return m(p) & dir[p];
      if (a % 3 == 2) return m(p) & pul[p];
      return m(p) & (dir[p] & drv[p*8 +: 8] | ~dir[p] & lat[p]);
   endfunction : exp_rd
   task automatic check(logic [63:0] seen, logic [63:0] want);
      checks++;
      if (seen !== want)
      begin
         errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic bus(logic w, int a, logic [7:0] d);
      @(posedge ref_clk);
      mem_wr <= w;
      mem_rd <= !w;
      mem_addr <= 5'(a);
      mem_wdata <= d;
      // Switch-free lines are expected high, which holds only while their pull-ups are on
      drv <= {$urandom, $urandom} | ~en;
      @(posedge ref_clk);
      mem_wr <= 0;
      mem_rd <= 0;
      @(posedge ref_clk);
      #1;
      if (!w) check(mem_rdata, exp_rd(a));
      else if (a == 24) wk = d;
      else if (a < 24 && a % 3 == 0) lat[a/3] = d;
      else if (a < 24 && a % 3 == 1) dir[a/3] = d;
      else if (a < 24) pul[a/3] = d;
   endtask : bus
   task automatic pins;
      for (int p = 0; p < 8; p++)
      begin
         check(pin_out[p*8 +: 8], lat[p] & m(p));
         check(pin_oe[p*8 +: 8], ~dir[p] & m(p));
         check(pin_pullup[p*8 +: 8], pul[p] & dir[p] & m(p));
      end
   endtask : pins
   task automatic fall(int i, bit h, int n);
      @(posedge ref_clk);
      drv[7:0] <= 8'hff;
      halted <= h;
      repeat (6) @(posedge ref_clk);
      base = wakes;
      drv[7:0] <= ~8'(1 << ((i + 1) % 8));
      repeat (8) @(posedge ref_clk);
      drv[7:0] <= ~8'(1 << i);
      repeat (8) @(posedge ref_clk);
      check(wakes - base, n);
      halted <= 0;
   endtask : fall
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up
   initial
   begin
      lat = '{default: 8'h00};
      dir = '{default: 8'hff};
      pul = '{default: 8'h00};
      void'($urandom(9984));
      repeat (2) @(posedge ref_clk);
      rstn <= 1;
      for (int a = 0; a < 32; a++) bus(0, a, 8'h00);
      pins();
      repeat (300) bus(1'($urandom), $urandom % 32, 8'($urandom));
      pins();
      en[23:16] <= 8'h00;
      bus(1, 7, 8'hff);
      bus(1, 8, 8'hff);
      bus(0, 6, 8'h00);
      en <= '1;
      bus(1, 1, 8'hff);
      for (int i = 0; i < 8; i++)
      begin
         bus(1, 24, 8'(1 << i));
         fall(i, 1, 1);
      end
      fall(7, 0, 0);
      wrap_up();
   end
   initial
   begin
      #100us;
      errors++;
      wrap_up();
   end
endmodule : gpio_ports_with_wakeup_test
bind gpio_ports gpio_ports_assertions #(.PORT_WIDTHS(PORT_WIDTHS)) u_gpio_ports_assertions
   (.ref_clk, .rstn, .mem_addr, .mem_wr, .mem_rd, .mem_wdata, .mem_rdata, .halted, .wake_req,
   .pin_in, .pin_out, .pin_oe, .pin_pullup);

//--- tb/pin_model.sv
// Board side of the pins: switches, weak pull-ups, floating lines
`timescale 1ns/10ps
module pin_model
(
   // Clock
   input wire logic ref_clk,
   // Device side
   input wire logic [63:0] pin_out,
   input wire logic [63:0] pin_oe,
   input wire logic [63:0] pin_pullup,
   // Switches
   input wire logic [63:0] ext_drive,
   input wire logic [63:0] ext_en,
   output logic [63:0] pin_in
);
   logic [63:0] float_q = '0;
   // Undriven lines wander so no level is assumed
   always @(posedge ref_clk) float_q <= ~float_q;
   assign pin_in = pin_oe & pin_out | ~pin_oe & ext_en & ext_drive
      | ~pin_oe & ~ext_en & (pin_pullup | float_q);
endmodule : pin_model
